// ===== tb/mpio_board.sv
/*
 Board circuitry on one 8-bit port: resolves each pin from port drive and board level.
 Assumes the board level is set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mpio_board (
    input wire logic [7:0] out,
    input wire logic [7:0] oe,
    input wire logic [7:0] ext,
    output wire logic [7:0] pin
);
    // ==========================================
    // driven bits follow the port, released bits take the board
    assign pin = (out & oe) | (ext & ~oe);
endmodule // mpio_board
`default_nettype wire

// ===== tb/mpio_chk_sva.sv
/*
 Checker for the multiplexed port set, watching top-level ports only.
 Assumes one clock CLK and synchronous active-low RSTN.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module mpio_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] PORTA_OE,
    input wire logic [7:0] PORTB_OE,
    input wire logic [7:0] PORTC_IN,
    input wire logic [5:0] PORTE_IN,
    input wire logic [1:0] PORTE_OUT,
    input wire logic [7:0] PORTG_OUT,
    input wire logic PWM_IN,
    input wire logic TIMER_SQUARE_WAVE_OUT,
    input wire logic DUTY_DETECT_OUT,
    input wire logic FAST_ADJUST_DIVIDER_OUT,
    input wire logic SLOW_ADJUST_DIVIDER_OUT,
    input wire logic REALTIME_PULSE_LOAD,
    input wire logic [3:0] REALTIME_PULSE_GENERATOR,
    input wire logic [7:0] KEY_RETURN_INPUT,
    input wire logic [3:0] EXTERNAL_IRQ_INPUT,
    input wire logic [1:0] EVENT_COUNT_INPUT,
    input wire logic NMI_REQ
);
    // ==========================================
    // selector mirror and properties
    logic [3:0] esel_q;
    logic [3:0] esel_d;
    wire logic [3:0] src;
    assign src = {SLOW_ADJUST_DIVIDER_OUT, FAST_ADJUST_DIVIDER_OUT, DUTY_DETECT_OUT, TIMER_SQUARE_WAVE_OUT};
    assign esel_d = (WR && ADDR == `MPIO_E_SEL) ? WDATA[3:0] : esel_q;
    always_ff @(posedge CLK)
        esel_q <= RSTN ? esel_d : 4'h0;
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_settled;
        $past(RSTN, 2) && $past(RSTN);
    endsequence
    sequence s_lone_dir_wr;
        (WR && ADDR == `MPIO_A_DIR) ##1 !(WR && ADDR == `MPIO_A_DIR);
    endsequence
    property p_b7_drive; PORTB_OE[7]; endproperty
    property p_a_dir; s_lone_dir_wr |=> PORTA_OE == $past(WDATA, 2); endproperty
    property p_e7_mux; esel_q[3] |=> PORTE_OUT[1] == $past(src[esel_q[2:1]]); endproperty
    property p_e6_pwm; esel_q[0] |=> PORTE_OUT[0] == $past(PWM_IN); endproperty
    property p_rt_or;
        REALTIME_PULSE_LOAD |=> ##1
            (PORTG_OUT[3:0] & $past(REALTIME_PULSE_GENERATOR, 2)) == $past(REALTIME_PULSE_GENERATOR, 2);
    endproperty
    property p_key_sync; s_settled |-> KEY_RETURN_INPUT == $past(PORTC_IN, 2); endproperty
    property p_irq_sync;
        s_settled |-> EXTERNAL_IRQ_INPUT == $past(PORTE_IN[3:0], 2) && EVENT_COUNT_INPUT == EXTERNAL_IRQ_INPUT[1:0];
    endproperty
    property p_nmi; NMI_REQ == EXTERNAL_IRQ_INPUT[3]; endproperty
    property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
    property p_unmapped; RD && ADDR > `MPIO_OUT_SEL |=> RDATA == 8'h00; endproperty
    a_b7_drive: assert property (p_b7_drive) else $error("b7 not driven");
    a_a_dir: assert property (p_a_dir) else $error("a enable wrong");
    a_e7_mux: assert property (p_e7_mux) else $error("e7 source wrong");
    a_e6_pwm: assert property (p_e6_pwm) else $error("e6 pwm wrong");
    a_rt_or: assert property (p_rt_or) else $error("g pulse bits missing");
    a_key_sync: assert property (p_key_sync) else $error("key return wrong");
    a_irq_sync: assert property (p_irq_sync) else $error("irq lines wrong");
    a_nmi: assert property (p_nmi) else $error("nmi wrong");
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule // mpio_chk
bind mpio_port_set mpio_chk i_mpio_chk (.*);
`default_nettype wire

// ===== tb/mpio_port_set_test.sv
/*
 Register-level testbench of the multiplexed port set.
 Assumes the design and board model are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module mpio_port_set_test;
    logic CLK, RSTN, WR, RD, SER0_DATA, SER0_EN, SER1_DATA, SER1_EN, PWM_IN, REALTIME_PULSE_LOAD;
    wire logic TIMER_SQUARE_WAVE_OUT, DUTY_DETECT_OUT, FAST_ADJUST_DIVIDER_OUT, SLOW_ADJUST_DIVIDER_OUT;
    logic [7:0] ADDR, WDATA, RDATA, DISPLAY_SEG_HI, DISPLAY_DIGIT_SEL, ext;
    logic [7:0] PORTA_IN, PORTA_OUT, PORTA_OE, PORTB_IN, PORTB_OUT, PORTB_OE, PORTC_IN, PORTC_OUT, PORTC_OE;
    logic [7:0] PORTG_IN, PORTG_OUT, PORTG_OE, PORTH_IN, PORTH_OUT, PORTH_OE, PORTD_OUT, PORTF_OUT, PORTI_OUT;
    logic [7:0] DIGIT_OUT, COMBINED_OUT, KEY_RETURN_INPUT;
    logic [5:0] PORTE_IN;
    logic [1:0] PORTE_OUT, EVENT_COUNT_INPUT;
    logic [3:0] REALTIME_PULSE_GENERATOR, EXTERNAL_IRQ_INPUT, src;
    logic [23:0] SEGMENT_DATA;
    logic [15:0] DISPLAY_DIGIT;
    logic NMI_REQ, REMOTE_RECEIVE_INPUT, DUTY_DETECT_INPUT, CAPTURE_INPUT;
    int fail_count, n_checks, cycles;
    assign {SLOW_ADJUST_DIVIDER_OUT, FAST_ADJUST_DIVIDER_OUT, DUTY_DETECT_OUT, TIMER_SQUARE_WAVE_OUT} = src;
    mpio_port_set i_mpio_port_set (.*);
    mpio_board i_mpio_board_a (.out(PORTA_OUT), .oe(PORTA_OE), .ext(ext), .pin(PORTA_IN));
    mpio_board i_mpio_board_b (.out(PORTB_OUT), .oe(PORTB_OE), .ext(ext), .pin(PORTB_IN));
    mpio_board i_mpio_board_c (.out(PORTC_OUT), .oe(PORTC_OE), .ext(ext), .pin(PORTC_IN));
    mpio_board i_mpio_board_g (.out(PORTG_OUT), .oe(PORTG_OE), .ext(ext), .pin(PORTG_IN));
    mpio_board i_mpio_board_h (.out(PORTH_OUT), .oe(PORTH_OE), .ext(ext), .pin(PORTH_IN));
    // ==========================================
    // clock, watchdog and bus tasks
    always #25 CLK = ~CLK;
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk("rdata", RDATA, exp);
    endtask
    // ==========================================
    // tests
    initial
    begin
        {CLK, RSTN, WR, RD, SER0_DATA, SER0_EN, SER1_DATA, SER1_EN, PWM_IN, REALTIME_PULSE_LOAD} = 10'h000;
        {ADDR, WDATA, DISPLAY_SEG_HI, DISPLAY_DIGIT_SEL, ext, PORTE_IN, src} = 50'h0;
        {REALTIME_PULSE_GENERATOR, SEGMENT_DATA, DISPLAY_DIGIT} = 44'h0;
        {fail_count, n_checks, cycles} = 0;
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        tick(2);
        chk("b_oe", PORTB_OE, 8'h80);
        chk("b_out", PORTB_OUT, 8'h80);
        chk("a_oe", PORTA_OE, 8'h00);
        chk("e_out", {6'h00, PORTE_OUT}, 8'h03);
        chk("g_out", PORTG_OUT, 8'h00);
        chk("d_out", PORTD_OUT, 8'h00);
        chk("c_oe", PORTC_OE, 8'h00);
        chk("g_oe", PORTG_OE, 8'h00);
        chk("h_oe", PORTH_OE, 8'h00);
        $display("reset done");
        @(posedge CLK) ext <= 8'h5a;
        wr(`MPIO_A_DATA, 8'h3c);
        wr(`MPIO_A_DIR, 8'hf0);
        tick(3);
        chk("a_oe", PORTA_OE, 8'hf0);
        chk("a_out", PORTA_OUT, 8'h3c);
        rd(`MPIO_A_DATA, 8'h3a);
        $display("port a done");
        wr(`MPIO_B_DIR, 8'hff);
        wr(`MPIO_B_DATA, 8'h00);
        tick(2);
        chk("b_oe", PORTB_OE, 8'hff);
        chk("b_out", PORTB_OUT, 8'h00);
        @(posedge CLK) {SER1_EN, SER1_DATA, SER0_EN, SER0_DATA} <= 4'hf;
        wr(`MPIO_B_DIR, 8'h00);
        tick(2);
        chk("b_oe", PORTB_OE, 8'h80);
        chk("b_out7", {7'h00, PORTB_OUT[7]}, 8'h01);
        wr(`MPIO_OUT_SEL, 8'h30);
        tick(2);
        chk("b_oe", PORTB_OE, 8'h90);
        chk("b_out", PORTB_OUT, 8'h90);
        $display("port b done");
        @(posedge CLK) PORTE_IN <= 6'h2a;
        tick(3);
        rd(`MPIO_E_DATA, 8'hea);
        chk("irq", {4'h0, EXTERNAL_IRQ_INPUT}, 8'h0a);
        chk("event", {6'h00, EVENT_COUNT_INPUT}, 8'h02);
        chk("nmi", {7'h00, NMI_REQ}, 8'h01);
        chk("e_hi", {6'h00, REMOTE_RECEIVE_INPUT, DUTY_DETECT_INPUT}, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            wr(`MPIO_E_SEL, {4'h0, 1'b1, c[1:0], 1'b0});
            @(posedge CLK) src <= 4'h1 << c;
            tick(2);
            chk("e7_sel", {7'h00, PORTE_OUT[1]}, 8'h01);
            @(posedge CLK) src <= ~(4'h1 << c);
            tick(2);
            chk("e7_sel", {7'h00, PORTE_OUT[1]}, 8'h00);
        end
        wr(`MPIO_E_SEL, 8'h01);
        tick(2);
        chk("e6_pwm", {6'h00, PORTE_OUT}, 8'h02);
        @(posedge CLK) PWM_IN <= 1'b1;
        tick(2);
        chk("e6_pwm", {6'h00, PORTE_OUT}, 8'h03);
        wr(`MPIO_E_SEL, 8'h00);
        wr(`MPIO_E_DATA, 8'h3f);
        tick(2);
        chk("e_out", {6'h00, PORTE_OUT}, 8'h00);
        $display("port e done");
        wr(`MPIO_G_DIR, 8'hff);
        @(posedge CLK) {REALTIME_PULSE_LOAD, REALTIME_PULSE_GENERATOR} <= 5'h15;
        @(posedge CLK) REALTIME_PULSE_LOAD <= 1'b0;
        tick(2);
        chk("g_out", PORTG_OUT, 8'h05);
        wr(`MPIO_G_DATA, 8'ha3);
        tick(2);
        chk("g_out", PORTG_OUT, 8'ha7);
        wr(`MPIO_RT_DATA, 8'h00);
        tick(2);
        chk("g_out", PORTG_OUT, 8'ha3);
        $display("port g done");
        wr(`MPIO_H_DIR, 8'h0f);
        wr(`MPIO_H_DATA, 8'ha5);
        tick(3);
        chk("h_oe", PORTH_OE, 8'h0f);
        chk("h_out", PORTH_OUT, 8'ha5);
        rd(`MPIO_H_DATA, 8'h55);
        $display("port h done");
        @(posedge CLK) {SEGMENT_DATA, DISPLAY_DIGIT, DISPLAY_SEG_HI, DISPLAY_DIGIT_SEL} <= 56'ha55a3c_5ac3_0f_f0;
        wr(`MPIO_D_DATA, 8'h81);
        tick(2);
        chk("d_out", PORTD_OUT, 8'h81);
        chk("digit", DIGIT_OUT, 8'h00);
        wr(`MPIO_OUT_SEL, 8'h2f);
        tick(2);
        chk("d_out", PORTD_OUT, 8'h3c);
        chk("f_out", PORTF_OUT, 8'h5a);
        chk("i_out", PORTI_OUT, 8'ha5);
        chk("digit", DIGIT_OUT, 8'hc3);
        chk("combined", COMBINED_OUT, 8'h5f);
        $display("display done");
        @(posedge CLK) ext <= 8'h97;
        wr(`MPIO_C_DATA, 8'h3c);
        tick(3);
        chk("key", KEY_RETURN_INPUT, 8'h97);
        chk("c_out", PORTC_OUT, 8'h3c);
        chk("c_oe", PORTC_OE, 8'h00);
        chk("capture", {7'h00, CAPTURE_INPUT}, 8'h01);
        rd(`MPIO_C_DATA, 8'h97);
        rd(8'h20, 8'h00);
        $display("keys done");
        conclude();
    end
endmodule // mpio_port_set_test
`default_nettype wire

// ===== verilog/mpio_defs.vh
/*
 Register offsets, field positions and reset values of the multiplexed port set.
 Assumes an 8-bit register port with byte-wide registers at the offsets below.
*/
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH
// ==========================================
// register offsets
`define MPIO_A_DATA 8'h00
`define MPIO_A_DIR 8'h01
`define MPIO_B_DATA 8'h02
`define MPIO_B_DIR 8'h03
`define MPIO_C_DATA 8'h04
`define MPIO_C_DIR 8'h05
`define MPIO_D_DATA 8'h06
`define MPIO_F_DATA 8'h07
`define MPIO_I_DATA 8'h08
`define MPIO_E_DATA 8'h09
`define MPIO_E_SEL 8'h0a
`define MPIO_G_DATA 8'h0b
`define MPIO_G_DIR 8'h0c
`define MPIO_H_DATA 8'h0d
`define MPIO_H_DIR 8'h0e
`define MPIO_RT_DATA 8'h0f
`define MPIO_OUT_SEL 8'h10
// ==========================================
// field positions
`define MPIO_E_SEL_PWM 0
`define MPIO_E_SEL_CODE_LO 1
`define MPIO_E_SEL_CODE_HI 2
`define MPIO_E_SEL_MUX 3
`define MPIO_OSEL_D 0
`define MPIO_OSEL_F 1
`define MPIO_OSEL_I 2
`define MPIO_OSEL_T 3
`define MPIO_OSEL_SER0 4
`define MPIO_OSEL_SER1 5
`define MPIO_E_OUT_MASK 8'hc0
`define MPIO_B_DIR_MASK 8'h7f
`define MPIO_RT_MASK 8'h0f
// ==========================================
// top-bit selector codes
`define MPIO_CODE_TIMER 2'h0
`define MPIO_CODE_DUTY 2'h1
`define MPIO_CODE_FAST 2'h2
`define MPIO_CODE_SLOW 2'h3
// ==========================================
// reset values
`define MPIO_RST_DIR 8'h00
`define MPIO_RST_DATA 8'h00
`define MPIO_RST_B_DATA 8'h80
`define MPIO_RST_E_DATA 8'hc0
`define MPIO_RST_E_SEL 8'h00
`define MPIO_RST_OUT_SEL 8'h20
`define MPIO_RST_RT 8'h00
`endif

// ===== verilog/mpio_port_set.v
/*
 Multiplexed port set: direction and data latches, output selectors, pin read-back.
 Assumes a CPU register port on CLK and peripheral signals from logic on CLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module mpio_port_set (
    input wire CLK,
    input wire RSTN,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire [7:0] PORTA_IN,
    output reg [7:0] PORTA_OUT,
    output reg [7:0] PORTA_OE,
    input wire [7:0] PORTB_IN,
    output reg [7:0] PORTB_OUT,
    output reg [7:0] PORTB_OE,
    input wire [7:0] PORTC_IN,
    output reg [7:0] PORTC_OUT,
    output reg [7:0] PORTC_OE,
    input wire [5:0] PORTE_IN,
    output reg [1:0] PORTE_OUT,
    input wire [7:0] PORTG_IN,
    output reg [7:0] PORTG_OUT,
    output reg [7:0] PORTG_OE,
    input wire [7:0] PORTH_IN,
    output reg [7:0] PORTH_OUT,
    output reg [7:0] PORTH_OE,
    output reg [7:0] PORTD_OUT,
    output reg [7:0] PORTF_OUT,
    output reg [7:0] PORTI_OUT,
    output reg [7:0] DIGIT_OUT,
    output reg [7:0] COMBINED_OUT,
    input wire SER0_DATA,
    input wire SER0_EN,
    input wire SER1_DATA,
    input wire SER1_EN,
    input wire PWM_IN,
    input wire TIMER_SQUARE_WAVE_OUT,
    input wire DUTY_DETECT_OUT,
    input wire FAST_ADJUST_DIVIDER_OUT,
    input wire SLOW_ADJUST_DIVIDER_OUT,
    input wire REALTIME_PULSE_LOAD,
    input wire [3:0] REALTIME_PULSE_GENERATOR,
    input wire [23:0] SEGMENT_DATA,
    input wire [15:0] DISPLAY_DIGIT,
    input wire [7:0] DISPLAY_SEG_HI,
    input wire [7:0] DISPLAY_DIGIT_SEL,
    output wire [7:0] KEY_RETURN_INPUT,
    output wire [3:0] EXTERNAL_IRQ_INPUT,
    output wire [1:0] EVENT_COUNT_INPUT,
    output wire NMI_REQ,
    output wire REMOTE_RECEIVE_INPUT,
    output wire DUTY_DETECT_INPUT,
    output wire CAPTURE_INPUT
);
    // ==========================================
    // latches
    reg [7:0] a_data_q;
    reg [7:0] a_dir_q;
    reg [7:0] b_data_q;
    reg [7:0] b_dir_q;
    reg [7:0] c_data_q;
    reg [7:0] c_dir_q;
    reg [7:0] d_data_q;
    reg [7:0] f_data_q;
    reg [7:0] i_data_q;
    reg [7:0] e_data_q;
    reg [7:0] e_sel_q;
    reg [7:0] g_data_q;
    reg [7:0] g_dir_q;
    reg [7:0] h_data_q;
    reg [7:0] h_dir_q;
    reg [7:0] rt_data_q;
    reg [7:0] out_sel_q;
    reg [7:0] rdata_d;
    reg e7_mux;
    wire [7:0] a_sync;
    wire [7:0] b_sync;
    wire [7:0] c_sync;
    wire [7:0] e_sync;
    wire [7:0] g_sync;
    wire [7:0] h_sync;

    // pin level where the bit is an input, latch where it drives
    function [7:0] readback;
        input [7:0] pins;
        input [7:0] latch;
        input [7:0] dir;
        begin
            readback = (pins & ~dir) | (latch & dir);
        end
    endfunction

    function [7:0] pick;
        input sel;
        input [7:0] alt;
        input [7:0] latch;
        begin
            pick = sel ? alt : latch;
        end
    endfunction

    // ==========================================
    // pin synchronisers
    mpio_sync u_sync_a (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in(PORTA_IN),
        .pin_sync(a_sync)
    );
    mpio_sync u_sync_b (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in(PORTB_IN),
        .pin_sync(b_sync)
    );
    mpio_sync u_sync_c (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in(PORTC_IN),
        .pin_sync(c_sync)
    );
    mpio_sync u_sync_e (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in({2'h0, PORTE_IN}),
        .pin_sync(e_sync)
    );
    mpio_sync u_sync_g (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in(PORTG_IN),
        .pin_sync(g_sync)
    );
    mpio_sync u_sync_h (
        .clk(CLK),
        .rstn(RSTN),
        .pin_in(PORTH_IN),
        .pin_sync(h_sync)
    );

    // ==========================================
    // peripheral inputs
    assign KEY_RETURN_INPUT = c_sync;
    assign EXTERNAL_IRQ_INPUT = e_sync[3:0];
    assign EVENT_COUNT_INPUT = e_sync[1:0];
    assign NMI_REQ = e_sync[3];
    assign REMOTE_RECEIVE_INPUT = e_sync[4];
    assign DUTY_DETECT_INPUT = e_sync[5];
    assign CAPTURE_INPUT = b_sync[0];

    // ==========================================
    // register writes
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            a_data_q <= `MPIO_RST_DATA;
            a_dir_q <= `MPIO_RST_DIR;
            b_data_q <= `MPIO_RST_B_DATA;
            b_dir_q <= `MPIO_RST_DIR;
            c_data_q <= `MPIO_RST_DATA;
            c_dir_q <= `MPIO_RST_DIR;
            d_data_q <= `MPIO_RST_DATA;
            f_data_q <= `MPIO_RST_DATA;
            i_data_q <= `MPIO_RST_DATA;
            e_data_q <= `MPIO_RST_E_DATA;
            e_sel_q <= `MPIO_RST_E_SEL;
            g_data_q <= `MPIO_RST_DATA;
            g_dir_q <= `MPIO_RST_DIR;
            h_data_q <= `MPIO_RST_DATA;
            h_dir_q <= `MPIO_RST_DIR;
            rt_data_q <= `MPIO_RST_RT;
            out_sel_q <= `MPIO_RST_OUT_SEL;
        end
        else
        begin
            if (WR)
            begin
                case (ADDR)
                    `MPIO_A_DATA: a_data_q <= WDATA;
                    `MPIO_A_DIR: a_dir_q <= WDATA;
                    `MPIO_B_DATA: b_data_q <= WDATA;
                    `MPIO_B_DIR: b_dir_q <= WDATA & `MPIO_B_DIR_MASK;
                    `MPIO_C_DATA: c_data_q <= WDATA;
                    `MPIO_C_DIR: c_dir_q <= WDATA;
                    `MPIO_D_DATA: d_data_q <= WDATA;
                    `MPIO_F_DATA: f_data_q <= WDATA;
                    `MPIO_I_DATA: i_data_q <= WDATA;
                    `MPIO_E_DATA: e_data_q <= WDATA & `MPIO_E_OUT_MASK;
                    `MPIO_E_SEL: e_sel_q <= {4'h0, WDATA[3:0]};
                    `MPIO_G_DATA: g_data_q <= WDATA;
                    `MPIO_G_DIR: g_dir_q <= WDATA;
                    `MPIO_H_DATA: h_data_q <= WDATA;
                    `MPIO_H_DIR: h_dir_q <= WDATA;
                    `MPIO_OUT_SEL: out_sel_q <= {2'h0, WDATA[5:0]};
                    default:
                    begin
                    end
                endcase
            end
            // generator load wins over a software write in the same cycle
            if (REALTIME_PULSE_LOAD)
            begin
                rt_data_q <= {4'h0, REALTIME_PULSE_GENERATOR};
            end
            else if (WR && ADDR == `MPIO_RT_DATA)
            begin
                rt_data_q <= WDATA & `MPIO_RT_MASK;
            end
        end
    end

    // ==========================================
    // read-back
    always @*
    begin
        case (ADDR)
            `MPIO_A_DATA: rdata_d = readback(a_sync, a_data_q, a_dir_q);
            `MPIO_A_DIR: rdata_d = a_dir_q;
            `MPIO_B_DATA: rdata_d = readback(b_sync, b_data_q, b_dir_q | 8'h80);
            `MPIO_B_DIR: rdata_d = b_dir_q;
            `MPIO_C_DATA: rdata_d = readback(c_sync, c_data_q, c_dir_q);
            `MPIO_C_DIR: rdata_d = c_dir_q;
            `MPIO_D_DATA: rdata_d = d_data_q;
            `MPIO_F_DATA: rdata_d = f_data_q;
            `MPIO_I_DATA: rdata_d = i_data_q;
            `MPIO_E_DATA: rdata_d = readback(e_sync, e_data_q, `MPIO_E_OUT_MASK);
            `MPIO_E_SEL: rdata_d = e_sel_q;
            `MPIO_G_DATA: rdata_d = readback(g_sync, g_data_q, g_dir_q);
            `MPIO_G_DIR: rdata_d = g_dir_q;
            `MPIO_H_DATA: rdata_d = readback(h_sync, h_data_q, h_dir_q);
            `MPIO_H_DIR: rdata_d = h_dir_q;
            `MPIO_RT_DATA: rdata_d = rt_data_q;
            `MPIO_OUT_SEL: rdata_d = out_sel_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            RDATA <= 8'h00;
        end
        else if (RD)
        begin
            RDATA <= rdata_d;
        end
        else
        begin
            RDATA <= 8'h00;
        end
    end

    // ==========================================
    // mixed port top-bit selector
    always @*
    begin
        case (e_sel_q[`MPIO_E_SEL_CODE_HI:`MPIO_E_SEL_CODE_LO])
            `MPIO_CODE_TIMER: e7_mux = TIMER_SQUARE_WAVE_OUT;
            `MPIO_CODE_DUTY: e7_mux = DUTY_DETECT_OUT;
            `MPIO_CODE_FAST: e7_mux = FAST_ADJUST_DIVIDER_OUT;
            `MPIO_CODE_SLOW: e7_mux = SLOW_ADJUST_DIVIDER_OUT;
            default: e7_mux = TIMER_SQUARE_WAVE_OUT;
        endcase
    end

    // ==========================================
    // pin drivers, all registered
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            PORTA_OUT <= 8'h00;
            PORTA_OE <= 8'h00;
            PORTB_OUT <= 8'h80;
            PORTB_OE <= 8'h80;
            PORTC_OUT <= 8'h00;
            PORTC_OE <= 8'h00;
            PORTE_OUT <= 2'h3;
            PORTG_OUT <= 8'h00;
            PORTG_OE <= 8'h00;
            PORTH_OUT <= 8'h00;
            PORTH_OE <= 8'h00;
            PORTD_OUT <= 8'h00;
            PORTF_OUT <= 8'h00;
            PORTI_OUT <= 8'h00;
            DIGIT_OUT <= 8'h00;
            COMBINED_OUT <= 8'h00;
        end
        else
        begin
            // input-mode A pins stay undriven for the converter
            PORTA_OUT <= a_data_q;
            PORTA_OE <= a_dir_q;
            PORTB_OUT[3:0] <= b_data_q[3:0];
            PORTB_OUT[6:5] <= b_data_q[6:5];
            PORTB_OUT[4] <= out_sel_q[`MPIO_OSEL_SER0] ? SER0_DATA : b_data_q[4];
            PORTB_OUT[7] <= (out_sel_q[`MPIO_OSEL_SER1] && SER1_EN) ? SER1_DATA : b_data_q[7];
            PORTB_OE[3:0] <= b_dir_q[3:0];
            PORTB_OE[6:5] <= b_dir_q[6:5];
            PORTB_OE[4] <= out_sel_q[`MPIO_OSEL_SER0] ? SER0_EN : b_dir_q[4];
            PORTB_OE[7] <= 1'b1;
            PORTC_OUT <= c_data_q;
            PORTC_OE <= c_dir_q;
            PORTE_OUT[0] <= e_sel_q[`MPIO_E_SEL_PWM] ? PWM_IN : e_data_q[6];
            PORTE_OUT[1] <= e_sel_q[`MPIO_E_SEL_MUX] ? e7_mux : e_data_q[7];
            PORTG_OUT <= g_data_q | rt_data_q;
            PORTG_OE <= g_dir_q;
            PORTH_OUT <= h_data_q;
            PORTH_OE <= h_dir_q;
            PORTD_OUT <= pick(out_sel_q[`MPIO_OSEL_D], SEGMENT_DATA[7:0], d_data_q);
            PORTF_OUT <= pick(out_sel_q[`MPIO_OSEL_F], SEGMENT_DATA[15:8], f_data_q);
            PORTI_OUT <= pick(out_sel_q[`MPIO_OSEL_I], SEGMENT_DATA[23:16], i_data_q);
            // display lines stay low until the display is enabled
            DIGIT_OUT <= out_sel_q[`MPIO_OSEL_T] ? DISPLAY_DIGIT[7:0] : 8'h00;
            COMBINED_OUT <= out_sel_q[`MPIO_OSEL_T] ?
                ((DISPLAY_DIGIT[15:8] & DISPLAY_DIGIT_SEL) | (DISPLAY_SEG_HI & ~DISPLAY_DIGIT_SEL)) : 8'h00;
        end
    end
endmodule // mpio_port_set
`default_nettype wire

// ===== verilog/mpio_sync.v
/*
 Two-flop synchroniser for one 8-bit group of pin inputs.
 Assumes the pins are asynchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module mpio_sync (
    input wire clk,
    input wire rstn,
    input wire [7:0] pin_in,
    output reg [7:0] pin_sync
);
    reg [7:0] meta_q;
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_q <= 8'h00;
            pin_sync <= 8'h00;
        end
        else
        begin
            meta_q <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule // mpio_sync
`default_nettype wire
